// file: design/pwrrec_pkg.sv
package pwrrec_pkg;

    localparam logic [7:0] CMD_READ_EVENT_RECORD   = 8'hd7;
    localparam logic [7:0] CMD_READ_STARTUP_TRACE  = 8'hdb;
    localparam logic [7:0] CMD_READ_STATUS_HISTORY = 8'hdf;
    localparam logic [7:0] CMD_RESTORE_DEFAULT_ALL = 8'h12;
    localparam logic [7:0] CMD_STORE_USER_ALL      = 8'h15;

    localparam int         EVENT_BYTES     = 32;
    localparam int         TRACE_BYTES     = 32;
    localparam int         HISTORY_BYTES   = 32;
    localparam int         TRACE_PAIRS     = 15;
    localparam int         HISTORY_WORDS   = 15;
    localparam int         SETTING_WORDS   = 16;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;
    localparam logic [7:0] COUNT_STEP      = 8'h01;
    localparam int         TRACE_FAIL_BIT  = 6;
    localparam int         TRACE_DATA_BASE = 2;

    localparam int EV_VIN_OLD   = 0;
    localparam int EV_VOUT_OLD  = 2;
    localparam int EV_IOUT_OLD  = 4;
    localparam int EV_DUTY_OLD  = 6;
    localparam int EV_VIN       = 8;
    localparam int EV_VOUT      = 10;
    localparam int EV_IOUT      = 12;
    localparam int EV_TEMP1     = 14;
    localparam int EV_TEMP2     = 16;
    localparam int EV_OPTIME    = 18;
    localparam int EV_STATUS    = 20;
    localparam int EV_STAT_BYTE = 22;
    localparam int EV_STAT_VOUT = 23;
    localparam int EV_STAT_IOUT = 24;
    localparam int EV_STAT_TEMP = 25;
    localparam int EV_STAT_CML  = 26;
    localparam int EV_STAT_OTH  = 27;
    localparam int EV_STAT_MFR  = 28;
    localparam int EV_CYCLES    = 29;

    localparam int      CLK_HZ           = 25_000_000;
    localparam int      HISTORY_PERIOD_S = 8;
    localparam longint  HISTORY_CYCLES   = longint'(CLK_HZ) * HISTORY_PERIOD_S;

    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] duty;
        logic [15:0] temp1;
        logic [15:0] temp2;
        logic [15:0] opTime;
        logic [15:0] statusWord;
        logic [7:0]  statusByte;
        logic [7:0]  statusVout;
        logic [7:0]  statusIout;
        logic [7:0]  statusTemp;
        logic [7:0]  statusCml;
        logic [7:0]  statusOther;
        logic [7:0]  statusMfr;
    } pwrrec_telemetry_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [4:0] index;
    } pwrrec_read_type;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RAMP    = 3'b001,
        ST_RUN     = 3'b010,
        ST_FAILED  = 3'b011,
        ST_SAVING  = 3'b100
    } pwrrec_state_type;

endpackage

// file: design/pwrrec_recorder.sv
`timescale 1ns/100ps
// Behaviour
// (R1) input loss while running saves event record
// (R2) good ramp with input ok erases record
// (R3) command d7 returns stored event record
// (R4) old fields latched at fault instant
// (R5) remaining fields written at input turn-off
// (R6) record holds old, present, temps, status, cycles
// (R7) command db returns 32 byte trace
// (R8) fifteen sample pairs spread over ramp time
// (R9) counter bytes 0-1, then vin/vout pairs
// (R10) trace counter is snapshot cycles plus one
// (R11) only first ramp; failure sets bit six
// (R12) successful ramp leaves trace all ff
// (R13) command df returns counter plus fifteen words
// (R14) history: counter, status, every 8 s
// (R15) restore default copies factory into working
// (R16) store user copies working into user area
// (R17) working values loaded from user at init
// (R18) host waits 5 ms after store; the host model waits STORE_WAIT = 125 cycles
// (R19) counters sent low byte first
module pwrrec_recorder
    import pwrrec_pkg::*;
#(
    parameter longint HISTORY_TICKS = HISTORY_CYCLES,
    parameter logic [15:0] FACTORY_VALUE = 16'h0000
)(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire pwrrec_telemetry_type telemetry,
    input  wire logic                 vinOkPin,
    input  wire logic                 rampActive,
    input  wire logic                 rampDone,
    input  wire logic                 rampFail,
    input  wire logic                 faultEvent,
    input  wire logic [31:0]          rampCycles,
    input  wire pwrrec_read_type      readReq,
    input  wire logic [7:0]           cmdCode,
    input  wire logic                 cmdStrobe,
    input  wire logic [3:0]           settingAddr,
    input  wire logic                 settingWrite,
    input  wire logic [15:0]          settingData,
    output logic [7:0]                readData,
    output logic                      readValid,
    output logic                      traceFailFlag,
    output logic [15:0]               settingOut,
    output logic                      nvmBusy
);
    ////////////////////////////////////////////////////////////////
    logic             vinSync1_q, vinOk_q, vinOkLast_q;
    logic [7:0]       event_q  [EVENT_BYTES];
    logic [7:0]       trace_q  [TRACE_BYTES];
    logic [7:0]       hist_q   [HISTORY_BYTES];
    logic [15:0]      factory_q[SETTING_WORDS];
    logic [15:0]      user_q   [SETTING_WORDS] = '{default: FACTORY_VALUE};
    logic [15:0]      work_q   [SETTING_WORDS];
    logic [15:0]      cycles_q;
    logic [15:0]      traceCount_q;
    logic [4:0]       pairIdx_q;
    logic [3:0]       histIdx_q;
    logic             histRun_q;
    logic             firstRampSeen_q;
    logic             initLoad_q;
    logic [15:0]      oldVin_q, oldVout_q, oldIout_q, oldDuty_q;
    pwrrec_state_type state_q;
    logic             sampleTick, histTick;
    logic             vinFall;
    logic [31:0]      samplePeriod;

    // pin crosses into clk domain through two flops
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            vinSync1_q  <= 1'b0;
            vinOk_q     <= 1'b0;
            vinOkLast_q <= 1'b0;
        end
        else
        begin
            vinSync1_q  <= vinOkPin;
            vinOk_q     <= vinSync1_q;
            vinOkLast_q <= vinOk_q;
        end
    end
    assign vinFall = vinOkLast_q && !vinOk_q;

    ////////////////////////////////////////////////////////////////
    // interval scaled so 15 pairs cover the ramp
    // a period of zero ticks every cycle, so short ramps still sample
    assign samplePeriod = rampCycles / 32'(TRACE_PAIRS); // R8

    pwrrec_tick #(.WIDTH(32)) u_sample (
        .clk    (clk),
        .reset  (reset),
        .run    (state_q == ST_RAMP),
        .period (samplePeriod),
        .tick   (sampleTick)
    );

    pwrrec_tick #(.WIDTH(40)) u_hist (
        .clk    (clk),
        .reset  (reset),
        .run    (histRun_q),
        .period (HISTORY_TICKS[39:0]),
        .tick   (histTick)
    );

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:   if (rampActive && !firstRampSeen_q) state_q <= ST_RAMP;
                ST_RAMP:   if (rampFail) state_q <= ST_FAILED;
                           else if (rampDone) state_q <= ST_RUN;
                ST_RUN:    if (vinFall) state_q <= ST_SAVING;
                ST_FAILED: if (vinFall) state_q <= ST_SAVING;
                ST_SAVING: state_q <= ST_IDLE;
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    // first ramp of a power cycle only; rearmed by input loss
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            firstRampSeen_q <= 1'b0;
        else if (vinFall)
            firstRampSeen_q <= 1'b0;
        else if (state_q == ST_RAMP)
            firstRampSeen_q <= 1'b1; // R11
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            traceFailFlag <= 1'b0;
        else if (state_q == ST_RAMP && rampFail)
            traceFailFlag <= 1'b1; // R11
        else if (vinFall)
            traceFailFlag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // old values frozen at the fault instant
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            oldVin_q  <= 16'h0000;
            oldVout_q <= 16'h0000;
            oldIout_q <= 16'h0000;
            oldDuty_q <= 16'h0000;
        end
        else if (faultEvent)
        begin
            oldVin_q  <= telemetry.vin; // R4
            oldVout_q <= telemetry.vout;
            oldIout_q <= telemetry.iout;
            oldDuty_q <= telemetry.duty;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cycles_q <= 16'h0000;
        else if (state_q == ST_SAVING)
            cycles_q <= cycles_q + 16'h0001;
    end

    // event record; words stored low byte first
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < EVENT_BYTES; i++)
                event_q[i] <= ERASED_BYTE;
        end
        else if (vinFall && (state_q == ST_RUN || state_q == ST_FAILED)) // R1 R5
        begin
            {event_q[EV_VIN_OLD+1], event_q[EV_VIN_OLD]}   <= oldVin_q; // R6 R19
            {event_q[EV_VOUT_OLD+1], event_q[EV_VOUT_OLD]} <= oldVout_q;
            {event_q[EV_IOUT_OLD+1], event_q[EV_IOUT_OLD]} <= oldIout_q;
            {event_q[EV_DUTY_OLD+1], event_q[EV_DUTY_OLD]} <= oldDuty_q;
            {event_q[EV_VIN+1], event_q[EV_VIN]}           <= telemetry.vin;
            {event_q[EV_VOUT+1], event_q[EV_VOUT]}         <= telemetry.vout;
            {event_q[EV_IOUT+1], event_q[EV_IOUT]}         <= telemetry.iout;
            {event_q[EV_TEMP1+1], event_q[EV_TEMP1]}       <= telemetry.temp1;
            {event_q[EV_TEMP2+1], event_q[EV_TEMP2]}       <= telemetry.temp2;
            {event_q[EV_OPTIME+1], event_q[EV_OPTIME]}     <= telemetry.opTime;
            {event_q[EV_STATUS+1], event_q[EV_STATUS]}     <= telemetry.statusWord;
            event_q[EV_STAT_BYTE] <= telemetry.statusByte;
            event_q[EV_STAT_VOUT] <= telemetry.statusVout;
            event_q[EV_STAT_IOUT] <= telemetry.statusIout;
            event_q[EV_STAT_TEMP] <= telemetry.statusTemp;
            event_q[EV_STAT_CML]  <= telemetry.statusCml;
            event_q[EV_STAT_OTH]  <= telemetry.statusOther;
            event_q[EV_STAT_MFR]  <= {telemetry.statusMfr[7:TRACE_FAIL_BIT+1], traceFailFlag,
                                      telemetry.statusMfr[TRACE_FAIL_BIT-1:0]};
            {event_q[EV_CYCLES+1], event_q[EV_CYCLES]}     <= cycles_q + 16'h0001;
        end
        else if (state_q == ST_RAMP && rampDone && !rampFail && vinOk_q)
        begin
            for (int i = 0; i < EVENT_BYTES; i++)
                event_q[i] <= ERASED_BYTE; // R2
        end
    end

    ////////////////////////////////////////////////////////////////
    // start-up trace
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < TRACE_BYTES; i++)
                trace_q[i] <= ERASED_BYTE;
            pairIdx_q    <= 5'h00;
            traceCount_q <= 16'h0000;
        end
        else if (state_q == ST_IDLE && rampActive && !firstRampSeen_q)
        begin
            traceCount_q <= cycles_q + {8'h00, COUNT_STEP}; // R10
            trace_q[0]   <= cycles_q[7:0] + COUNT_STEP; // R9 R19
            trace_q[1]   <= cycles_q[15:8] + {7'h00, (cycles_q[7:0] == ERASED_BYTE)};
            pairIdx_q    <= 5'h00;
        end
        else if (state_q == ST_RAMP && rampDone && !rampFail)
        begin
            for (int i = 0; i < TRACE_BYTES; i++)
                trace_q[i] <= ERASED_BYTE; // R12
        end
        else if (state_q == ST_RAMP && sampleTick && pairIdx_q < 5'(TRACE_PAIRS))
        begin
            trace_q[TRACE_DATA_BASE + 2*pairIdx_q]     <= telemetry.vin[7:0]; // R8 R9
            trace_q[TRACE_DATA_BASE + 2*pairIdx_q + 1] <= telemetry.vout[7:0];
            pairIdx_q <= pairIdx_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // status history after the ramp
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < HISTORY_BYTES; i++)
                hist_q[i] <= ERASED_BYTE;
            histIdx_q <= 4'h0;
            histRun_q <= 1'b0;
        end
        else if (state_q == ST_RAMP && rampDone && !rampFail)
        begin
            {hist_q[1], hist_q[0]} <= traceCount_q; // R14 R19
            {hist_q[3], hist_q[2]} <= telemetry.statusWord;
            for (int i = 4; i < HISTORY_BYTES; i++)
                hist_q[i] <= ERASED_BYTE;
            histIdx_q <= 4'h1;
            histRun_q <= 1'b1;
        end
        else if (histRun_q && (vinFall || histIdx_q == 4'(HISTORY_WORDS)))
            histRun_q <= 1'b0;
        else if (histRun_q && histTick)
        begin
            hist_q[2 + 2*histIdx_q]     <= telemetry.statusWord[7:0]; // R13 R14
            hist_q[2 + 2*histIdx_q + 1] <= telemetry.statusWord[15:8];
            histIdx_q <= histIdx_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // settings areas: factory fixed, user writable, working live
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            for (int i = 0; i < SETTING_WORDS; i++)
                factory_q[i] <= FACTORY_VALUE;
    end

    // non-volatile: reset must not undo a store
    always_ff @(posedge clk)
    begin
        if (cmdStrobe && cmdCode == CMD_STORE_USER_ALL)
            for (int i = 0; i < SETTING_WORDS; i++)
                user_q[i] <= work_q[i]; // R16
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            initLoad_q <= 1'b1;
            for (int i = 0; i < SETTING_WORDS; i++)
                work_q[i] <= 16'h0000;
        end
        else if (initLoad_q)
        begin
            initLoad_q <= 1'b0;
            for (int i = 0; i < SETTING_WORDS; i++)
                work_q[i] <= user_q[i]; // R17
        end
        else if (cmdStrobe && cmdCode == CMD_RESTORE_DEFAULT_ALL)
            for (int i = 0; i < SETTING_WORDS; i++)
                work_q[i] <= factory_q[i]; // R15
        else if (settingWrite)
            work_q[settingAddr] <= settingData;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            settingOut <= 16'h0000;
            nvmBusy    <= 1'b1;
        end
        else
        begin
            settingOut <= work_q[settingAddr];
            nvmBusy    <= initLoad_q || (cmdStrobe && cmdCode == CMD_STORE_USER_ALL); // R18
        end
    end

    ////////////////////////////////////////////////////////////////
    // read port: one byte per request, next cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            readData  <= 8'h00;
            readValid <= 1'b0;
        end
        else
        begin
            readValid <= readReq.valid;
            if (!readReq.valid)
                readData <= 8'h00;
            else if (readReq.code == CMD_READ_EVENT_RECORD)
                readData <= event_q[readReq.index]; // R3
            else if (readReq.code == CMD_READ_STARTUP_TRACE)
                readData <= trace_q[readReq.index]; // R7
            else if (readReq.code == CMD_READ_STATUS_HISTORY)
                readData <= hist_q[readReq.index]; // R13
            else
                readData <= ERASED_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////
    flag_fail_a: assert property (@(posedge clk) disable iff (reset)
        (state_q == ST_RAMP && rampFail) |=> traceFailFlag) // R11
        else $error("ramp failure did not raise flag");

    read_latency_a: assert property (@(posedge clk) disable iff (reset)
        readReq.valid |=> readValid) // R3
        else $error("read not answered next cycle");

    trace_erased_a: assert property (@(posedge clk) disable iff (reset) // R12
        (state_q == ST_RAMP && rampDone && !rampFail)
        |=> (trace_q[0] == ERASED_BYTE && trace_q[TRACE_BYTES-1] == ERASED_BYTE))
        else $error("trace not erased after good ramp");

    event_erased_a: assert property (@(posedge clk) disable iff (reset) // R2
        (state_q == ST_RAMP && rampDone && !rampFail && vinOk_q && !vinFall) |=> event_q[EV_CYCLES] == ERASED_BYTE)
        else $error("event record not erased");

    trace_count_a: assert property (@(posedge clk) disable iff (reset) // R10
        (state_q == ST_IDLE && rampActive && !firstRampSeen_q) |=> traceCount_q == $past(cycles_q) + 16'h0001)
        else $error("trace counter wrong");

    event_saved_a: assert property (@(posedge clk) disable iff (reset) // R1
        (vinFall && state_q == ST_RUN) |=> event_q[EV_VIN_OLD] == $past(oldVin_q[7:0]))
        else $error("old vin not saved");

    // a failed first ramp keeps later attempts out of the trace
    one_ramp_a: assert property (@(posedge clk) disable iff (reset) // R11
        (state_q == ST_FAILED && !vinFall) |=> state_q == ST_FAILED)
        else $error("second ramp recorded");

    restore_a: assert property (@(posedge clk) disable iff (reset) // R15
        (cmdStrobe && cmdCode == CMD_RESTORE_DEFAULT_ALL && !initLoad_q)
        |=> work_q[$past(settingAddr)] == factory_q[$past(settingAddr)])
        else $error("restore default failed");

    good_ramp_c: cover property (@(posedge clk) state_q == ST_RAMP ##1 state_q == ST_RUN);
    fail_ramp_c: cover property (@(posedge clk) state_q == ST_RAMP ##1 state_q == ST_FAILED);
    save_c:      cover property (@(posedge clk) state_q == ST_SAVING);
endmodule

// file: design/pwrrec_tick.sv
`timescale 1ns/100ps
module pwrrec_tick
    import pwrrec_pkg::*;
#(
    parameter int WIDTH = 32
)(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] period,
    output logic                  tick
);
    logic [WIDTH-1:0] count_q;

    // restart whenever run drops, so the first tick is a full period away
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            count_q <= '0;
            tick    <= 1'b0;
        end
        else if (!run)
        begin
            count_q <= '0;
            tick    <= 1'b0;
        end
        else if (count_q + 1'b1 >= period)
        begin
            count_q <= '0;
            tick    <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule

// file: test/pwrrec_host_model.sv
`timescale 1ns/100ps
module pwrrec_host_model
    import pwrrec_pkg::*;
#(
    parameter int STORE_WAIT = 125
)(
    input  wire logic       clk,
    output pwrrec_read_type readReq,
    output logic [7:0]      cmdCode,
    output logic            cmdStrobe,
    input  wire logic [7:0] readData,
    input  wire logic       readValid
);
    initial
    begin
        readReq   = '0;
        cmdCode   = 8'h00;
        cmdStrobe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one byte per request; code line inverted once released
    task automatic read_byte(input logic [7:0] code, input logic [4:0] index, output logic [7:0] data);
        data = 8'hxx;
        @(posedge clk);
        readReq <= '{valid: 1'b1, code: code, index: index};
        @(posedge clk);
        readReq.valid <= 1'b0;
        readReq.code  <= ~code;
        for (int n = 0; n < 4; n++)
        begin
            @(posedge clk);
            if (readValid === 1'b1)
            begin
                data = readData;
                break;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // busy flag is only a hint, so the full pause is always kept
    task automatic command(input logic [7:0] code);
        @(posedge clk);
        cmdCode   <= code;
        cmdStrobe <= 1'b1;
        @(posedge clk);
        cmdStrobe <= 1'b0;
        cmdCode   <= ~code;
        if (code == CMD_STORE_USER_ALL)
            repeat (STORE_WAIT) @(posedge clk);
    endtask
endmodule

// file: test/pwrrec_recorder_test.sv
`timescale 1ns/100ps
module pwrrec_recorder_test
    import pwrrec_pkg::*;
;
    localparam int          RAMP_LEN = 150;
    localparam longint      HISTORY  = 50;
    localparam logic [15:0] FACTORY  = 16'h0f0f;

    typedef struct packed {
        logic [7:0] code;
        logic [4:0] index;
        logic [7:0] data;
    } pwrrec_row_type;

    // history rows last: skipped once history is running
    pwrrec_row_type rows [8] = '{
        '{CMD_READ_EVENT_RECORD, 5'h00, ERASED_BYTE}, '{CMD_READ_EVENT_RECORD, 5'h1f, ERASED_BYTE},
        '{CMD_READ_STARTUP_TRACE, 5'h00, ERASED_BYTE}, '{CMD_READ_STARTUP_TRACE, 5'h1f, ERASED_BYTE},
        '{8'h00, 5'h00, ERASED_BYTE}, '{8'hd8, 5'h03, ERASED_BYTE},
        '{CMD_READ_STATUS_HISTORY, 5'h00, ERASED_BYTE}, '{CMD_READ_STATUS_HISTORY, 5'h1f, ERASED_BYTE}};

    logic                 clk;
    logic                 reset;
    pwrrec_telemetry_type telemetry;
    logic                 vinOkPin, rampActive, rampDone, rampFail, faultEvent, settingWrite;
    logic [31:0]          rampCycles;
    pwrrec_read_type      readReq;
    logic [7:0]           cmdCode, readData, got;
    logic                 cmdStrobe, readValid, traceFailFlag, nvmBusy;
    logic [3:0]           settingAddr;
    logic [15:0]          settingData, settingOut;
    int                   n_fail = 0;
    int                   checks = 0;
    int                   cycles = 0;

    pwrrec_recorder #(
        .HISTORY_TICKS (HISTORY),
        .FACTORY_VALUE (FACTORY)
    ) i_pwrrec_recorder (
        .clk           (clk),
        .reset         (reset),
        .telemetry     (telemetry),
        .vinOkPin      (vinOkPin),
        .rampActive    (rampActive),
        .rampDone      (rampDone),
        .rampFail      (rampFail),
        .faultEvent    (faultEvent),
        .rampCycles    (rampCycles),
        .readReq       (readReq),
        .cmdCode       (cmdCode),
        .cmdStrobe     (cmdStrobe),
        .settingAddr   (settingAddr),
        .settingWrite  (settingWrite),
        .settingData   (settingData),
        .readData      (readData),
        .readValid     (readValid),
        .traceFailFlag (traceFailFlag),
        .settingOut    (settingOut),
        .nvmBusy       (nvmBusy)
    );

    // store pause scaled down from milliseconds to keep the run short
    pwrrec_host_model #(
        .STORE_WAIT (125)
    ) i_pwrrec_host_model (
        .clk       (clk),
        .readReq   (readReq),
        .cmdCode   (cmdCode),
        .cmdStrobe (cmdStrobe),
        .readData  (readData),
        .readValid (readValid)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want)
        begin
            n_fail++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic expect_byte(input logic [7:0] code, input logic [4:0] index, input logic [7:0] want);
        i_pwrrec_host_model.read_byte(code, index, got);
        check({8'h00, got}, {8'h00, want});
    endtask

    task automatic run_rows(input int count);
        for (int r = 0; r < count; r++)
            expect_byte(rows[r].code, rows[r].index, rows[r].data);
    endtask

    task automatic ramp(input logic ok);
        @(posedge clk);
        rampActive <= 1'b1;
        repeat (RAMP_LEN + 4) @(posedge clk);
        rampActive <= 1'b0;
        rampDone   <= ok;
        rampFail   <= ~ok;
        @(posedge clk);
        rampDone <= 1'b0;
        rampFail <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset           = 1'b1;
        telemetry       = '0;
        telemetry.temp1 = 16'h0055;
        vinOkPin        = 1'b1;
        rampActive      = 1'b0;
        rampDone        = 1'b0;
        rampFail        = 1'b0;
        faultEvent      = 1'b0;
        rampCycles      = 32'(RAMP_LEN);
        settingAddr     = 4'h0;
        settingWrite    = 1'b0;
        settingData     = 16'h0000;
        repeat (8) @(posedge clk);
        check({15'h0000, readValid}, 16'h0000);
        check({15'h0000, nvmBusy}, 16'h0001);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        check({15'h0000, nvmBusy}, 16'h0000);
        check(settingOut, FACTORY);
        run_rows(8);
        // good ramp: records erased, history begins with the status word
        telemetry.statusWord <= 16'h0102;
        ramp(1'b1);
        repeat (3) @(posedge clk);
        telemetry.statusWord <= 16'h0304;
        expect_byte(CMD_READ_STATUS_HISTORY, 5'h02, 8'h02);
        expect_byte(CMD_READ_STATUS_HISTORY, 5'h03, 8'h01);
        expect_byte(CMD_READ_STATUS_HISTORY, 5'h00, 8'h01);
        expect_byte(CMD_READ_STATUS_HISTORY, 5'h01, 8'h00);
        repeat (60) @(posedge clk);
        expect_byte(CMD_READ_STATUS_HISTORY, 5'h04, 8'h04);
        run_rows(6);
        // old fields frozen at the fault, the rest at input loss
        telemetry.vin <= 16'h1a2b;
        @(posedge clk);
        faultEvent <= 1'b1;
        @(posedge clk);
        faultEvent    <= 1'b0;
        telemetry.vin <= 16'h3c4d;
        @(posedge clk);
        vinOkPin <= 1'b0;
        repeat (10) @(posedge clk);
        expect_byte(CMD_READ_EVENT_RECORD, 5'(EV_VIN_OLD), 8'h2b);
        expect_byte(CMD_READ_EVENT_RECORD, 5'(EV_VIN_OLD + 1), 8'h1a);
        expect_byte(CMD_READ_EVENT_RECORD, 5'(EV_VIN), 8'h4d);
        expect_byte(CMD_READ_EVENT_RECORD, 5'(EV_TEMP1), 8'h55);
        expect_byte(CMD_READ_EVENT_RECORD, 5'(EV_CYCLES), 8'h01);
        // new power cycle, failed first ramp, then an ignored retry
        vinOkPin <= 1'b1;
        repeat (6) @(posedge clk);
        ramp(1'b0);
        repeat (2) @(posedge clk);
        check({15'h0000, traceFailFlag}, 16'h0001);
        expect_byte(CMD_READ_STARTUP_TRACE, 5'h00, 8'h02);
        expect_byte(CMD_READ_STARTUP_TRACE, 5'h01, 8'h00);
        expect_byte(CMD_READ_STARTUP_TRACE, 5'(TRACE_DATA_BASE), 8'h4d);
        expect_byte(CMD_READ_STARTUP_TRACE, 5'(TRACE_BYTES - 1), 8'h00);
        expect_byte(CMD_READ_EVENT_RECORD, 5'(EV_VIN_OLD), 8'h2b);
        ramp(1'b1);
        expect_byte(CMD_READ_STARTUP_TRACE, 5'h00, 8'h02);
        // settings: edit, store, restore, reload at reset
        @(posedge clk);
        settingAddr  <= 4'h5;
        settingData  <= 16'habcd;
        settingWrite <= 1'b1;
        @(posedge clk);
        settingWrite <= 1'b0;
        repeat (2) @(posedge clk);
        check(settingOut, 16'habcd);
        i_pwrrec_host_model.command(CMD_STORE_USER_ALL);
        i_pwrrec_host_model.command(CMD_RESTORE_DEFAULT_ALL);
        repeat (2) @(posedge clk);
        check(settingOut, FACTORY);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        check(settingOut, 16'habcd);
        close_out();
    end
endmodule
